/* File: logic/key_wakeup_ports_h_j.sv */
`default_nettype none
`include "kwu_regs.svh"
module key_wakeup_ports_h_j (
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic                   stopMode,
   input  wire logic [`KWU_ADDR_W-1:0] addr,
   input  wire logic [7:0]             wrData,
   input  wire logic                   wrStb,
   input  wire logic                   rdStb,
   output logic      [7:0]             rdData,
   input  wire logic [7:0]             portHIn,
   output logic      [7:0]             portHOut,
   output logic      [7:0]             portHOe,
   input  wire logic [7:0]             portJIn,
   output logic      [7:0]             portJOut,
   output logic      [7:0]             portJOe,
   output logic      [7:0]             portJPullUp,
   output logic      [7:0]             portJPullDown,
   output logic                        wakeIrqH,
   output logic                        wakeIrqJ
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      kwu_pkg::byte_t hData;
      kwu_pkg::byte_t hDir;
      kwu_pkg::byte_t hWen;
      kwu_pkg::byte_t hFlg;
      kwu_pkg::byte_t jData;
      kwu_pkg::byte_t jDir;
      kwu_pkg::byte_t jWen;
      kwu_pkg::byte_t jFlg;
      kwu_pkg::byte_t jPol;
      kwu_pkg::byte_t jPsel;
      kwu_pkg::byte_t jPen;
      kwu_pkg::byte_t jPolOld;
      kwu_pkg::byte_t rd;
      kwu_pkg::rd_state_t rdState;
   } top_state_t;
   top_state_t st_r;
   top_state_t st_nxt;

   // ------------------------------------------------------------
   // edge detectors
   // ------------------------------------------------------------
   kwu_edge_if #(.W(8)) hEdge ();
   kwu_edge_if #(.W(8)) jEdge ();
   logic [7:0] hLevel;
   logic [7:0] jLevel;
   logic [7:0] jActive;
   logic [7:0] jPolChange;

   // pins are watched regardless of direction
   assign hEdge.level = portHIn;
   assign jEdge.level = portJIn;

   kwu_edge_detect #(.W(8)) uDetH (
      .core_clk  (core_clk),
      .reset     (reset),
      .stopMode  (stopMode),
      .edges     (hEdge),
      .syncLevel (hLevel)
   );
   kwu_edge_detect #(.W(8)) uDetJ (
      .core_clk  (core_clk),
      .reset     (reset),
      .stopMode  (stopMode),
      .edges     (jEdge),
      .syncLevel (jLevel)
   );

   // ------------------------------------------------------------
   // per-pin active edge for port j
   // ------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : gJ
      always_comb begin
         jActive[i] = st_r.jPol[i] ? jEdge.rise[i] : jEdge.fall[i];
         // a polarity flip onto the level already present looks like an edge
         jPolChange[i] = (st_r.jPol[i] != st_r.jPolOld[i])
                         && (jLevel[i] == st_r.jPol[i]);
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0] hRead;
   logic [7:0] jRead;
   assign hRead = (st_r.hDir & st_r.hData) | (~st_r.hDir & hLevel);
   assign jRead = (st_r.jDir & st_r.jData) | (~st_r.jDir & jLevel);

   always_comb begin
      st_nxt         = st_r;
      st_nxt.jPolOld = st_r.jPol;
      st_nxt.rdState = kwu_pkg::RD_IDLE;
      // any register, any time
      if (wrStb) begin
         case (addr)
            `KWU_OFF_H_DATA: st_nxt.hData = wrData;
            `KWU_OFF_H_DIR:  st_nxt.hDir  = wrData;
            `KWU_OFF_H_WEN:  st_nxt.hWen  = wrData;
            `KWU_OFF_H_WFLG: st_nxt.hFlg  = st_r.hFlg & ~wrData;
            `KWU_OFF_J_DATA: st_nxt.jData = wrData;
            `KWU_OFF_J_DIR:  st_nxt.jDir  = wrData;
            `KWU_OFF_J_WEN:  st_nxt.jWen  = wrData;
            `KWU_OFF_J_WFLG: st_nxt.jFlg  = st_r.jFlg & ~wrData;
            `KWU_OFF_J_POL:  st_nxt.jPol  = wrData;
            `KWU_OFF_J_PSEL: st_nxt.jPsel = wrData;
            `KWU_OFF_J_PEN:  st_nxt.jPen  = wrData;
            default: ;
         endcase
      end
      // set after clear so a same-cycle edge is never lost
      st_nxt.hFlg = st_nxt.hFlg | hEdge.fall;
      st_nxt.jFlg = st_nxt.jFlg | jActive | jPolChange;
      if (rdStb) begin
         st_nxt.rdState = kwu_pkg::RD_DONE;
         case (addr)
            `KWU_OFF_H_DATA: st_nxt.rd = hRead;
            `KWU_OFF_H_DIR:  st_nxt.rd = st_r.hDir;
            `KWU_OFF_H_WEN:  st_nxt.rd = st_r.hWen;
            `KWU_OFF_H_WFLG: st_nxt.rd = st_r.hFlg;
            `KWU_OFF_J_DATA: st_nxt.rd = jRead;
            `KWU_OFF_J_DIR:  st_nxt.rd = st_r.jDir;
            `KWU_OFF_J_WEN:  st_nxt.rd = st_r.jWen;
            `KWU_OFF_J_WFLG: st_nxt.rd = st_r.jFlg;
            `KWU_OFF_J_POL:  st_nxt.rd = st_r.jPol;
            `KWU_OFF_J_PSEL: st_nxt.rd = st_r.jPsel;
            `KWU_OFF_J_PEN:  st_nxt.rd = st_r.jPen;
            default:         st_nxt.rd = `KWU_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdData   = st_r.rd;
   assign portHOut = st_r.hData;
   assign portHOe  = st_r.hDir;
   assign portJOut = st_r.jData;
   assign portJOe  = st_r.jDir;
   // pull devices only on enabled inputs
   assign portJPullUp   = st_r.jPen & ~st_r.jDir & st_r.jPsel;
   assign portJPullDown = st_r.jPen & ~st_r.jDir & ~st_r.jPsel;
   // in stop the raw edge term bypasses the flag flops
   assign wakeIrqH = |((st_r.hFlg | (stopMode ? hEdge.fall : 8'h00)) & st_r.hWen);
   assign wakeIrqJ = |((st_r.jFlg | (stopMode ? jActive : 8'h00)) & st_r.jWen);
endmodule : key_wakeup_ports_h_j
`default_nettype wire

/* File: logic/kwu_regs.svh */
`ifndef KWU_REGS_SVH
`define KWU_REGS_SVH
`define KWU_ADDR_W          4
`define KWU_OFF_H_DATA      4'h0
`define KWU_OFF_H_DIR       4'h1
`define KWU_OFF_H_WEN       4'h2
`define KWU_OFF_H_WFLG      4'h3
`define KWU_OFF_J_DATA      4'h4
`define KWU_OFF_J_DIR       4'h5
`define KWU_OFF_J_WEN       4'h6
`define KWU_OFF_J_WFLG      4'h7
`define KWU_OFF_J_POL       4'h8
`define KWU_OFF_J_PSEL      4'h9
`define KWU_OFF_J_PEN       4'ha
`define KWU_RST_BYTE        8'h00
`endif

/* File: logic/kwu_pkg.sv */
`default_nettype none
package kwu_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DONE = 1'b1
   } rd_state_t;
endpackage : kwu_pkg
`default_nettype wire

/* File: logic/kwu_edge_if.sv */
`default_nettype none
interface kwu_edge_if #(parameter int W = 8);
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport det (input level, output rise, output fall);
   modport use_ (output level, input rise, input fall);
endinterface : kwu_edge_if
`default_nettype wire

/* File: logic/kwu_edge_detect.sv */
`default_nettype none
`include "kwu_regs.svh"
module kwu_edge_detect #(
   parameter int W = 8
) (
   input  wire logic   core_clk,
   input  wire logic   reset,
   input  wire logic   stopMode,
   kwu_edge_if.det     edges,
   output logic [W-1:0] syncLevel
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } det_state_t;
   det_state_t st_r;
   det_state_t st_nxt;
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = edges.level;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end
   // clocks frozen in stop: last sampled level is the previous state
   always_comb begin
      edges.rise = stopMode ? (edges.level & ~st_r.s3) : (st_r.s2 & ~st_r.s3);
      edges.fall = stopMode ? (~edges.level & st_r.s3) : (~st_r.s2 & st_r.s3);
   end
   assign syncLevel = st_r.s2;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : kwu_edge_detect
`default_nettype wire

/* File: test/key_pin_model.sv */
`default_nettype none
module key_pin_model (
   input  wire logic [7:0] key,
   input  wire logic [7:0] out,
   input  wire logic [7:0] oe,
   output logic      [7:0] pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // a driving port pin overrides the key, which is only a weak contact
   assign pin = (oe & out) | (~oe & key);
endmodule : key_pin_model
`default_nettype wire

/* File: test/kwu_monitor.sv */
`default_nettype none
module kwu_monitor (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       stopMode,
   input wire logic [3:0] addr,
   input wire logic [7:0] wrData,
   input wire logic       wrStb,
   input wire logic       rdStb,
   input wire logic [7:0] rdData,
   input wire logic [7:0] portHIn,
   input wire logic [7:0] portHOut,
   input wire logic [7:0] portHOe,
   input wire logic [7:0] portJOut,
   input wire logic [7:0] portJOe,
   input wire logic [7:0] portJPullUp,
   input wire logic [7:0] portJPullDown,
   input wire logic       wakeIrqH,
   input wire logic       wakeIrqJ
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // the sync chain may flag edges just after reset, so the clear check waits it out
   logic [2:0] age_r;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) age_r <= 3'h0;
      else if (age_r != 3'h7) age_r <= age_r + 3'h1;
   end
   property p_hDir; wrStb && addr == 4'h1 |=> portHOe == $past(wrData); endproperty
   a_hDir: assert property (p_hDir) else $error("port h direction");
   property p_jDir; wrStb && addr == 4'h5 |=> portJOe == $past(wrData); endproperty
   a_jDir: assert property (p_jDir) else $error("port j direction");
   property p_hOut; wrStb && addr == 4'h0 |=> portHOut == $past(wrData); endproperty
   a_hOut: assert property (p_hOut) else $error("port h latch");
   property p_jOut; wrStb && addr == 4'h4 |=> portJOut == $past(wrData); endproperty
   a_jOut: assert property (p_jOut) else $error("port j latch");
   property p_pullEx; (portJPullUp & portJPullDown) == 8'h00; endproperty
   a_pullEx: assert property (p_pullEx) else $error("both pulls on");
   property p_pullOe; ((portJPullUp | portJPullDown) & portJOe) == 8'h00; endproperty
   a_pullOe: assert property (p_pullOe) else $error("pull on output");
   property p_unmap; rdStb && addr > 4'ha |=> rdData == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_rdHold; !rdStb |=> $stable(rdData); endproperty
   a_rdHold: assert property (p_rdHold) else $error("read data moved");
   property p_hClr;
      wrStb && addr == 4'h3 && wrData == 8'hff && !stopMode && age_r == 3'h7 && $stable(portHIn)
      && portHIn == $past(portHIn, 2) && portHIn == $past(portHIn, 3)
      && portHIn == $past(portHIn, 4) |=> stopMode || !wakeIrqH;
   endproperty
   a_hClr: assert property (p_hClr) else $error("flags not cleared");
   c_irqH: cover property (wakeIrqH);
   c_irqJ: cover property (wakeIrqJ);
   c_stop: cover property (stopMode && wakeIrqH);
endmodule : kwu_monitor
bind key_wakeup_ports_h_j kwu_monitor mon (.core_clk(core_clk), .reset(reset),
   .stopMode(stopMode), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
   .rdData(rdData), .portHIn(portHIn), .portHOut(portHOut), .portHOe(portHOe),
   .portJOut(portJOut),
   .portJOe(portJOe), .portJPullUp(portJPullUp), .portJPullDown(portJPullDown),
   .wakeIrqH(wakeIrqH), .wakeIrqJ(wakeIrqJ));
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset, stopMode, wrStb, rdStb, irqH, irqJ;
   logic [3:0] addr;
   kwu_pkg::byte_t wrData, rdData, hOut, hOe, jOut, jOe, pu, pd, hPin, jPin, hKey, jKey;
   int n_errors, comparisons;
   key_wakeup_ports_h_j dut (.core_clk(core_clk), .reset(reset), .stopMode(stopMode),
      .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .portHIn(hPin), .portHOut(hOut), .portHOe(hOe), .portJIn(jPin), .portJOut(jOut),
      .portJOe(jOe), .portJPullUp(pu), .portJPullDown(pd), .wakeIrqH(irqH), .wakeIrqJ(irqJ));
   key_pin_model keyH (.key(hKey), .out(hOut), .oe(hOe), .pin(hPin));
   key_pin_model keyJ (.key(jKey), .out(jOut), .oe(jOe), .pin(jPin));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic check(input kwu_pkg::byte_t got, input kwu_pkg::byte_t exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input kwu_pkg::byte_t d);
      @(posedge core_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge core_clk);
      wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input kwu_pkg::byte_t exp);
      @(posedge core_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge core_clk);
      rdStb <= 1'b0;
      #1 check(rdData, exp);
   endtask : rd
   task automatic finish_test;
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // driving outputs low on j leaves falling-edge flags behind for the j scenario
   task automatic test_registers;
      wr(4'h1, 8'ha5);
      #1 check(hOe, 8'ha5);
      wr(4'h5, 8'h3c);
      #1 check(jOe, 8'h3c);
      rd(4'h1, 8'ha5);
      rd(4'h5, 8'h3c);
      rd(4'hf, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h5, 8'h00);
   endtask : test_registers
   task automatic test_port_h;
      wr(4'h2, 8'hff);
      wr(4'h3, 8'hff);
      #1 check({7'h0, irqH}, 8'h00);
      @(posedge core_clk) hKey <= 8'hf7;
      repeat (4) @(posedge core_clk);
      #1 check({7'h0, irqH}, 8'h01);
      rd(4'h3, 8'h08);
      wr(4'h3, 8'hf7);
      rd(4'h3, 8'h08);
      wr(4'h3, 8'h08);
      rd(4'h3, 8'h00);
      check({7'h0, irqH}, 8'h00);
   endtask : test_port_h
   task automatic test_port_j;
      wr(4'h6, 8'hff);
      wr(4'h8, 8'h01);
      rd(4'h7, 8'h3d);
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      @(posedge core_clk) jKey <= 8'hfe;
      repeat (4) @(posedge core_clk);
      rd(4'h7, 8'h00);
      @(posedge core_clk) jKey <= 8'hff;
      repeat (4) @(posedge core_clk);
      rd(4'h7, 8'h01);
      check({7'h0, irqJ}, 8'h01);
      wr(4'h7, 8'h01);
      wr(4'h4, 8'h00);
      wr(4'h5, 8'h02);
      rd(4'h4, 8'hfd);
      repeat (2) @(posedge core_clk);
      rd(4'h7, 8'h02);
      wr(4'h7, 8'h02);
      wr(4'h5, 8'h00);
   endtask : test_port_j
   task automatic test_pulls;
      wr(4'h9, 8'h0f);
      wr(4'ha, 8'h33);
      #1 check(pu, 8'h03);
      check(pd, 8'h30);
      wr(4'h5, 8'h01);
      #1 check(pu, 8'h02);
   endtask : test_pulls
   // wakeup must show before any flag flop could have caught the edge
   task automatic test_stop;
      @(posedge core_clk) stopMode <= 1'b1;
      @(posedge core_clk) hKey <= 8'hbf;
      #2 check({7'h0, irqH}, 8'h01);
   endtask : test_stop
   initial begin
      {stopMode, wrStb, rdStb, addr, wrData, n_errors, comparisons} = '0;
      hKey = 8'hff;
      jKey = 8'hff;
      reset = 1'b1;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      test_registers();
      test_port_h();
      test_port_j();
      test_pulls();
      test_stop();
      finish_test();
   end
endmodule : testbench
`default_nettype wire
